/* File: pot_ctrl_pkg.sv */
// Shared constants and types for the dual potentiometer serial controller
package pot_ctrl_pkg;

   // Array geometry
   localparam int          POT_COUNT     = 2;
   localparam int          SETTING_COUNT = 4;
   localparam int          WIPER_W       = 6;
   localparam int          TAP_COUNT     = 64;
   localparam logic [5:0]  WIPER_MAX     = 6'h3F;
   localparam logic [5:0]  WIPER_MIN     = 6'h00;
   localparam logic [5:0]  WIPER_STEP    = 6'h01;
   localparam logic [5:0]  SETTING_RESET = 6'h00;

   // Identification byte layout
   localparam int          TYPE_LSB      = 4;
   localparam int          ID_ZERO_LSB   = 2;
   localparam logic [1:0]  ID_ZERO_VAL   = 2'h0;

   // Instruction byte layout
   localparam int          OP_LSB        = 4;
   localparam int          SEL_LSB       = 2;
   localparam int          POT_BIT       = 0;

   // Instruction opcodes
   localparam logic [3:0]  OP_RD_WIPER   = 4'h9;
   localparam logic [3:0]  OP_WR_WIPER   = 4'hA;
   localparam logic [3:0]  OP_RD_SETTING = 4'hB;
   localparam logic [3:0]  OP_WR_SETTING = 4'hC;
   localparam logic [3:0]  OP_TO_WIPER   = 4'hD;
   localparam logic [3:0]  OP_TO_SETTING = 4'hE;
   localparam logic [3:0]  OP_GLB_TO_WIP = 4'h1;
   localparam logic [3:0]  OP_GLB_TO_SET = 4'h8;
   localparam logic [3:0]  OP_INCDEC     = 4'h2;
   localparam logic [3:0]  OP_RD_STATUS  = 4'h5;

   // Serial framing
   localparam logic [2:0]  LAST_BIT      = 3'h7;
   localparam logic [1:0]  RD_PAD        = 2'h0;
   localparam logic [6:0]  STATUS_PAD    = 7'h00;

   // Nonvolatile write time
   localparam int          NV_WRITE_MS     = 10;
   localparam int          SYS_CLK_MHZ     = 100;
   localparam int          NV_WRITE_CYCLES = NV_WRITE_MS * 1000 * SYS_CLK_MHZ;

   typedef enum logic [2:0] {
      ST_ID,
      ST_INSTR,
      ST_WRDATA,
      ST_RDDATA,
      ST_INCDEC,
      ST_DONE,
      ST_IGNORE
   } link_state_e;

endpackage

/* File: tap_decoder.sv */
// One-hot decoder from wiper position to tap switch enables
module tap_decoder #(
   parameter int WIDTH = 6,
   parameter int TAPS  = 64
) (
   // Position in
   input  wire logic [WIDTH-1:0] pos,
   // Switch enables out
   output      logic [TAPS-1:0]  tap_en
);

   // A single set bit shifted into place cannot enable two switches
   assign tap_en = TAPS'(1) << pos;

endmodule // tap_decoder

/* File: dual_pot_serial_wiper_ctrl.sv */
// Serial slave and wiper position control for a dual digital potentiometer
// Summary of operation
// RULE1: Sample serial input on rising serial clock
// RULE2: Shift read data out on falling edge
// RULE3: Chip select high: output released, standby (code raises STANDBY only while no nonvolatile write is pending or busy)
// RULE4: Ignore commands until chip select falls after reset
// RULE5: Pause input low freezes sequence state
// RULE6: Host changes pause only while clock low
// RULE7: Host holds pause high when unused
// RULE8: Host keeps select low, pause, protect high
// RULE9: Straps form address bits; mismatch aborts
// RULE10: Up to four devices share bus
// RULE11: Protect low blocks nonvolatile writes
// RULE12: Drive output only for read data
// RULE13: One wiper register per potentiometer
// RULE14: Wiper decodes to exactly one switch
// RULE15: Write wiper command loads serial value
// RULE16: Transfer commands load wiper from setting
// RULE17: Increment/decrement moves wiper one step
// RULE18: Reset loads wiper from setting zero
// RULE19: Wiper is volatile, lost at reset
// RULE20: Four stored settings per potentiometer
// RULE21: First byte: type, zeros, address bits
// RULE22: Second byte: opcode, setting, potentiometer
// RULE23: Each clock pulse steps by serial input
// RULE24: Setting writes take ten ms, flag busy
// RULE25: Wiper saturates at 63 and 0
// RULE26: Early deselect discards partial sequence
module dual_pot_serial_wiper_ctrl
   import pot_ctrl_pkg::*;
#(
   parameter logic [3:0] DEVICE_TYPE    = 4'hA,  // Value is arbitrary
   parameter int         NV_WRITE_COUNT = NV_WRITE_CYCLES
) (
   // System clock and reset
   input  wire logic                 SYS_CLK,
   input  wire logic                 RSTN,
   // Serial link
   input  wire logic                 SCK,
   input  wire logic                 CS_N,
   input  wire logic                 SI,
   output      logic                 SO,
   output      logic                 SO_OE_N,
   input  wire logic                 HOLD_N,
   // Straps and protection
   input  wire logic [1:0]           DEV_SEL,
   input  wire logic                 WP_N,
   // Potentiometer switch enables
   output      logic [TAP_COUNT-1:0] TAP_SEL0,
   output      logic [TAP_COUNT-1:0] TAP_SEL1,
   // Status
   output      logic                 NV_WRITE_PENDING,
   output      logic                 STANDBY
);

   localparam int CNT_W = $clog2(NV_WRITE_COUNT + 1);

   // Link-side state; sequence, command, read and output registers cleared whenever chip select is high
   wire               rst_link_n = RSTN & ~CS_N;
   link_state_e       state_ff;
   link_state_e       nxt_state;
   logic [2:0]        bitcnt_ff;
   logic [7:0]        shift_ff;
   logic [7:0]        nxt_shift;
   logic [3:0]        cmd_op_ff;
   logic [1:0]        cmd_sel_ff;
   logic              cmd_pot_ff;
   logic [7:0]        rd_byte_ff;
   logic              rd_load_ff;
   logic [7:0]        out_sr_ff;
   logic              oe_ff;
   logic [1:0][5:0]   wiper_ff;
   logic [1:0][3:0][5:0] stored_ff;
   logic              nv_tog_ff;
   logic [4:0]        link_meta_ff;
   logic [4:0]        link_sync_ff;

   // System-side state
   logic              cs_meta_ff;
   logic              cs_sync_ff;
   logic [2:0]        tog_sync_ff;
   logic              armed_ff;
   logic              pending_ff;
   logic              busy_ff;
   logic [CNT_W-1:0]  nv_cnt_ff;

   // Decode helpers
   logic              go;
   logic              byte_done;
   logic              id_ok;
   logic              instr_edge;
   logic              data_edge;
   logic [3:0]        op;
   logic [1:0]        sel;
   logic              pot;
   logic              wip_s;
   logic              armed_s;
   logic              wp_s;
   logic [1:0]        dev_s;
   logic              nv_ok;
   logic              nv_req;
   logic              is_read;
   logic              nv_start;
   logic [5:0]        cur;

   function automatic logic [5:0] step_pos(input logic [5:0] p, input logic up);
      if (up) begin
         step_pos = (p == WIPER_MAX) ? p : p + WIPER_STEP;  // RULE25
      end else begin
         step_pos = (p == WIPER_MIN) ? p : p - WIPER_STEP;  // RULE25
      end
   endfunction

   // Pause is synchronous to the serial clock by the host's own timing
   assign go         = HOLD_N;  // RULE5
   assign nxt_shift  = {shift_ff[6:0], SI};  // RULE1
   assign byte_done  = go && (bitcnt_ff == LAST_BIT);
   assign op         = nxt_shift[OP_LSB +: 4];  // RULE22
   assign sel        = nxt_shift[SEL_LSB +: 2];
   assign pot        = nxt_shift[POT_BIT];
   assign wip_s      = link_sync_ff[4];
   assign armed_s    = link_sync_ff[3];
   assign wp_s       = link_sync_ff[2];
   assign dev_s      = link_sync_ff[1:0];
   assign id_ok      = armed_s && (nxt_shift[TYPE_LSB +: 4] == DEVICE_TYPE)
                       && (nxt_shift[ID_ZERO_LSB +: 2] == ID_ZERO_VAL)
                       && (nxt_shift[1:0] == dev_s);  // RULE4 RULE9 RULE10 RULE21
   assign instr_edge = byte_done && (state_ff == ST_INSTR);
   assign data_edge  = byte_done && (state_ff == ST_WRDATA);
   assign is_read    = (op == OP_RD_WIPER) || (op == OP_RD_SETTING)
                       || (op == OP_RD_STATUS);
   assign nv_ok      = wp_s && !wip_s;  // RULE11
   assign nv_req     = (instr_edge && ((op == OP_TO_SETTING) || (op == OP_GLB_TO_SET)))
                       || (data_edge && (cmd_op_ff == OP_WR_SETTING));
   assign cur        = wiper_ff[cmd_pot_ff];

   // Straps, protect and system status into the link domain
   always_ff @(posedge SCK or negedge RSTN) begin
      if (!RSTN) begin
         link_meta_ff <= 5'h00;
         link_sync_ff <= 5'h00;
      end else begin
         link_meta_ff <= {busy_ff | pending_ff, armed_ff, WP_N, DEV_SEL};
         link_sync_ff <= link_meta_ff;
      end
   end

   // Sequence tracking; deselect resets it and drops partial commands
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_ID: begin
            if (byte_done) begin
               nxt_state = id_ok ? ST_INSTR : ST_IGNORE;  // RULE9
            end
         end
         ST_INSTR: begin
            if (byte_done) begin
               case (op)
                  OP_RD_WIPER, OP_RD_SETTING, OP_RD_STATUS: nxt_state = ST_RDDATA;
                  OP_WR_WIPER, OP_WR_SETTING:               nxt_state = ST_WRDATA;
                  OP_INCDEC:                                nxt_state = ST_INCDEC;
                  OP_TO_WIPER, OP_TO_SETTING,
                  OP_GLB_TO_WIP, OP_GLB_TO_SET:             nxt_state = ST_DONE;
                  default:                                  nxt_state = ST_IGNORE;
               endcase
            end
         end
         ST_WRDATA, ST_RDDATA: begin
            if (byte_done) begin
               nxt_state = ST_DONE;
            end
         end
         default: nxt_state = state_ff;
      endcase
   end

   always_ff @(posedge SCK or negedge rst_link_n) begin
      if (!rst_link_n) begin
         state_ff  <= ST_ID;  // RULE26
         bitcnt_ff <= 3'h0;
         shift_ff  <= 8'h00;
      end else if (go) begin  // RULE5
         state_ff  <= nxt_state;
         bitcnt_ff <= bitcnt_ff + 3'h1;
         shift_ff  <= nxt_shift;  // RULE1
      end
   end

   always_ff @(posedge SCK or negedge rst_link_n) begin
      if (!rst_link_n) begin
         cmd_op_ff  <= 4'h0;
         cmd_sel_ff <= 2'h0;
         cmd_pot_ff <= 1'b0;
      end else if (instr_edge) begin
         cmd_op_ff  <= op;
         cmd_sel_ff <= sel;
         cmd_pot_ff <= pot;
      end
   end

   // Wipers survive deselect but not reset, which reloads setting zero
   always_ff @(posedge SCK or negedge RSTN) begin
      if (!RSTN) begin
         wiper_ff <= {POT_COUNT{SETTING_RESET}};  // RULE18 RULE19
      end else if (instr_edge && (op == OP_TO_WIPER)) begin
         wiper_ff[pot] <= stored_ff[pot][sel];  // RULE16
      end else if (instr_edge && (op == OP_GLB_TO_WIP)) begin
         for (int p = 0; p < POT_COUNT; p++) begin
            wiper_ff[p] <= stored_ff[p][sel];  // RULE16
         end
      end else if (data_edge && (cmd_op_ff == OP_WR_WIPER)) begin
         wiper_ff[cmd_pot_ff] <= nxt_shift[5:0];  // RULE15
      end else if (go && (state_ff == ST_INCDEC)) begin
         wiper_ff[cmd_pot_ff] <= step_pos(cur, SI);  // RULE17 RULE23
      end
   end

   // Stored settings; new contents are visible at once, busy covers the burn
   always_ff @(posedge SCK or negedge RSTN) begin
      if (!RSTN) begin
         stored_ff <= {(POT_COUNT * SETTING_COUNT){SETTING_RESET}};  // RULE20
         nv_tog_ff <= 1'b0;
      end else if (nv_req && nv_ok) begin  // RULE11
         nv_tog_ff <= ~nv_tog_ff;  // RULE24
         if (data_edge) begin
            stored_ff[cmd_pot_ff][cmd_sel_ff] <= nxt_shift[5:0];
         end else if (op == OP_TO_SETTING) begin
            stored_ff[pot][sel] <= wiper_ff[pot];
         end else begin
            for (int p = 0; p < POT_COUNT; p++) begin
               stored_ff[p][sel] <= wiper_ff[p];
            end
         end
      end
   end

   // Read data captured at the end of the instruction byte
   always_ff @(posedge SCK or negedge rst_link_n) begin
      if (!rst_link_n) begin
         rd_byte_ff <= 8'h00;
         rd_load_ff <= 1'b0;
      end else if (go) begin
         rd_load_ff <= instr_edge && is_read;
         if (instr_edge) begin
            case (op)
               OP_RD_WIPER:   rd_byte_ff <= {RD_PAD, wiper_ff[pot]};
               OP_RD_SETTING: rd_byte_ff <= {RD_PAD, stored_ff[pot][sel]};
               OP_RD_STATUS:  rd_byte_ff <= {STATUS_PAD, wip_s};  // RULE24
               default:       rd_byte_ff <= 8'h00;
            endcase
         end
      end
   end

   // Output shifter on the falling edge so data is stable at the host's rise
   always_ff @(negedge SCK or negedge rst_link_n) begin
      if (!rst_link_n) begin
         out_sr_ff <= 8'h00;
         oe_ff     <= 1'b0;  // RULE3
      end else if (go) begin
         if (rd_load_ff) begin
            out_sr_ff <= rd_byte_ff;  // RULE2
            oe_ff     <= 1'b1;  // RULE12
         end else begin
            out_sr_ff <= {out_sr_ff[6:0], 1'b0};  // RULE2
         end
      end
   end

   assign SO      = out_sr_ff[7];
   assign SO_OE_N = ~(oe_ff & HOLD_N);  // RULE3 RULE12

   // Switch decode, one instance per potentiometer
   tap_decoder #(.WIDTH(WIPER_W), .TAPS(TAP_COUNT)) u_dec0 (
      .pos    (wiper_ff[0]),
      .tap_en (TAP_SEL0)
   );  // RULE13 RULE14

   tap_decoder #(.WIDTH(WIPER_W), .TAPS(TAP_COUNT)) u_dec1 (
      .pos    (wiper_ff[1]),
      .tap_en (TAP_SEL1)
   );  // RULE13 RULE14

   // System domain: chip select level and write toggle crossings
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         cs_meta_ff  <= 1'b0;
         cs_sync_ff  <= 1'b0;
         tog_sync_ff <= 3'h0;
      end else begin
         cs_meta_ff  <= CS_N;
         cs_sync_ff  <= cs_meta_ff;
         tog_sync_ff <= {tog_sync_ff[1:0], nv_tog_ff};
      end
   end

   // A deselect must be seen before the first command after reset
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         armed_ff <= 1'b0;
      end else if (cs_sync_ff) begin
         armed_ff <= 1'b1;  // RULE4
      end
   end

   // The burn starts when the host deselects after a complete write
   assign nv_start = pending_ff && cs_sync_ff && !busy_ff;

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pending_ff <= 1'b0;
      end else begin
         pending_ff <= (tog_sync_ff[2] ^ tog_sync_ff[1]) | (pending_ff & ~nv_start);
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         busy_ff   <= 1'b0;
         nv_cnt_ff <= '0;
      end else if (nv_start) begin
         busy_ff   <= 1'b1;  // RULE24
         nv_cnt_ff <= CNT_W'(NV_WRITE_COUNT - 1);
      end else if (busy_ff) begin
         if (nv_cnt_ff == '0) begin
            busy_ff <= 1'b0;
         end else begin
            nv_cnt_ff <= nv_cnt_ff - CNT_W'(1);
         end
      end
   end

   assign NV_WRITE_PENDING = pending_ff | busy_ff;  // RULE24
   assign STANDBY          = cs_sync_ff & ~pending_ff & ~busy_ff;  // RULE3

   // Checks on the link domain
   a_id_filter: assert property (@(posedge SCK) disable iff (!rst_link_n)
      (state_ff == ST_ID && byte_done && !id_ok) |=> state_ff == ST_IGNORE) // RULE9
      else $error("mismatched identification byte accepted");

   a_power_gate: assert property (@(posedge SCK) disable iff (!rst_link_n)
      (state_ff == ST_ID && byte_done && !armed_s) |=> state_ff != ST_INSTR) // RULE4
      else $error("command accepted before first deselect");

   a_incdec_up: assert property (@(posedge SCK) disable iff (!rst_link_n)
      (state_ff == ST_INCDEC && go && SI && cur != WIPER_MAX)
      |=> cur == 6'($past(cur) + WIPER_STEP)) // RULE23
      else $error("increment did not move wiper by one");

   a_wiper_sat: assert property (@(posedge SCK) disable iff (!rst_link_n)
      (state_ff == ST_INCDEC && go && SI && cur == WIPER_MAX)
      |=> cur == WIPER_MAX) // RULE25
      else $error("wiper wrapped above top");

   a_hold_freeze: assert property (@(posedge SCK) disable iff (!rst_link_n)
      !HOLD_N |=> $stable(bitcnt_ff) && $stable(state_ff) && $stable(shift_ff)) // RULE5
      else $error("sequence advanced while paused");

   // Reset only on power: the next edge often falls in the following frame
   a_nv_block: assert property (@(posedge SCK) disable iff (!RSTN)
      (nv_req && !nv_ok) |=> $stable(stored_ff)) // RULE11
      else $error("stored setting changed while protected or busy");

   a_xfer_load: assert property (@(posedge SCK) disable iff (!RSTN)
      (instr_edge && op == OP_TO_WIPER)
      |=> wiper_ff[$past(pot)] == stored_ff[$past(pot)][$past(sel)]) // RULE16
      else $error("transfer did not load wiper");

   a_wr_wiper: assert property (@(posedge SCK) disable iff (!RSTN)
      (data_edge && cmd_op_ff == OP_WR_WIPER)
      |=> wiper_ff[$past(cmd_pot_ff)] == $past(nxt_shift[5:0])) // RULE15
      else $error("write wiper did not load serial value");

   a_out_release: assert property (@(posedge SCK) disable iff (!rst_link_n)
      (state_ff inside {ST_ID, ST_INSTR, ST_WRDATA, ST_INCDEC}) |-> SO_OE_N) // RULE12
      else $error("serial output driven outside read data");

   // Checks on the system domain
   a_tap_onehot: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      $onehot(TAP_SEL0) && $onehot(TAP_SEL1)) // RULE14
      else $error("switch enables not one-hot");

   a_nv_start: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      nv_start |=> busy_ff && nv_cnt_ff == CNT_W'(NV_WRITE_COUNT - 1)) // RULE24
      else $error("write timer not loaded at start");

   a_nv_end: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (busy_ff && nv_cnt_ff == '0 && !nv_start) |=> !busy_ff ##0 NV_WRITE_PENDING == pending_ff) // RULE24
      else $error("write busy not cleared at terminal count");

   c_incdec: cover property (@(posedge SCK) disable iff (!rst_link_n)
      state_ff == ST_INCDEC && go ##1 state_ff == ST_INCDEC && go);
   c_read: cover property (@(negedge SCK) disable iff (!rst_link_n) rd_load_ff && go);
   c_nv_write: cover property (@(posedge SYS_CLK) disable iff (!RSTN) nv_start);
   c_pause: cover property (@(posedge SCK) disable iff (!rst_link_n)
      state_ff == ST_WRDATA && !HOLD_N);

endmodule // dual_pot_serial_wiper_ctrl

/* File: pot_host.sv */
// Behavioural host master driving the serial link of the potentiometer controller
module pot_host (
   // Serial link toward the device
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   output logic      hold_n,
   // Serial reply
   input  wire logic so,
   input  wire logic so_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;

   localparam int HALF = 15;

   logic line;

   // Released output shows the inverse of its last value, so a stale bit never passes
   assign line = so_oe_n ? ~so : so;

   // Select starts low to show that the device stays unarmed until it sees a deselect
   initial begin
      sck = 1'b0;
      cs_n = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end

   task automatic select();
      cs_n = 1'b0;
      #HALF;
   endtask

   // Clock stands still low between frames
   task automatic deselect();
      si = 1'b0;
      cs_n = 1'b1;
      #(4*HALF);
   endtask

   // Mode 0: data set while clock low, reply sampled at the rise
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx, output logic oe);
      oe = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         si = tx[i];
         #HALF sck = 1'b1;
         rx[i] = line;
         oe = oe | ~so_oe_n;
         #HALF sck = 1'b0;
      end
   endtask

   task automatic pulses(input int n, input logic up);
      si = up;
      repeat (n) begin
         #HALF sck = 1'b1;
         #HALF sck = 1'b0;
      end
   endtask

   // Clock edges given while paused carry noise that the device must ignore
   task automatic pause(input int n);
      hold_n = 1'b0;
      repeat (n) begin
         si = ~si;
         #HALF sck = 1'b1;
         #HALF sck = 1'b0;
      end
      hold_n = 1'b1;
      #HALF;
   endtask
endmodule // pot_host

/* File: tb.sv */
// Self-checking bench for the dual potentiometer serial controller
module tb import pot_ctrl_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int         NV_COUNT = 200;
   localparam logic [3:0] DEV_TYPE = 4'hA;  // Value is arbitrary
   localparam logic [1:0] STRAPS   = 2'h2;

   logic        sys_clk;
   logic        rstn;
   logic        wp_n;
   logic [1:0]  dev_sel;
   logic [1:0]  id_adr;
   logic        sck, cs_n, si, hold_n, so, so_oe_n, pending, standby;
   logic [63:0] tap0, tap1;
   int          n_errors = 0;
   int          total_checks = 0;

   always #5 sys_clk = ~sys_clk;

   dual_pot_serial_wiper_ctrl #(.DEVICE_TYPE(DEV_TYPE), .NV_WRITE_COUNT(NV_COUNT))
   dual_pot_serial_wiper_ctrl_i (
      .SYS_CLK(sys_clk), .RSTN(rstn), .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so),
      .SO_OE_N(so_oe_n), .HOLD_N(hold_n), .DEV_SEL(dev_sel), .WP_N(wp_n),
      .TAP_SEL0(tap0), .TAP_SEL1(tap1), .NV_WRITE_PENDING(pending), .STANDBY(standby));

   pot_host pot_host_i (
      .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe_n(so_oe_n));

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Waits for the write pending flag to rise and then to fall, both bounded
   task automatic nv_wait();
      int i;
      for (int k = 1; k >= 0; k--) begin
         for (i = 0; i < 4*NV_COUNT && pending !== k[0]; i++) @(posedge sys_clk);
         if (pending !== k[0]) begin
            n_errors++;
            $display("BAD nv_write_pending expected %0d seen %b", k, pending);
            complete_run();
         end
      end
   endtask

   task automatic head(input logic [3:0] op, input logic [1:0] sel, input logic pot,
                       output logic oe);
      logic [7:0] r;
      logic       o1;
      logic       o2;
      @(posedge sys_clk);
      #1;
      pot_host_i.select();
      pot_host_i.shift({DEV_TYPE, ID_ZERO_VAL, id_adr}, r, o1);
      pot_host_i.shift({op, sel, 1'b0, pot}, r, o2);
      oe = o1 | o2;
   endtask

   // Data byte only for the three-byte opcodes
   task automatic cmd(input logic [3:0] op, input logic [1:0] sel, input logic pot,
                      input logic [7:0] data, output logic [7:0] rd, output logic oe);
      logic o;
      head(op, sel, pot, oe);
      rd = 8'h00;
      if (op inside {OP_RD_WIPER, OP_WR_WIPER, OP_RD_SETTING, OP_WR_SETTING, OP_RD_STATUS}) begin
         pot_host_i.shift(data, rd, o);
         check("so_oe_n data", o, !(op inside {OP_WR_WIPER, OP_WR_SETTING}));
      end
      pot_host_i.deselect();
   endtask

   task automatic incdec(input logic pot, input int n, input logic up);
      logic oe;
      head(OP_INCDEC, 2'h0, pot, oe);
      pot_host_i.pulses(n, up);
      pot_host_i.deselect();
   endtask

   initial begin
      logic [7:0] rd;
      logic       oe;
      sys_clk = 1'b0;
      rstn = 1'b0;
      wp_n = 1'b1;
      dev_sel = STRAPS;
      id_adr = STRAPS;
      repeat (2) @(posedge sys_clk);
      #1 rstn = 1'b1;
      cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h15, rd, oe);
      check("tap_sel1 unarmed", tap1, 64'h1);
      check("tap_sel0 reset", tap0, 64'h1);
      check("standby", standby, 1'b1);
      $display("Test unarmed done");

      cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h15, rd, oe);
      check("tap_sel1", tap1, 64'h1 << 6'h15);
      check("tap_sel0", tap0, 64'h1);
      check("so_oe_n in command", oe, 1'b0);
      cmd(OP_RD_WIPER, 2'h0, 1'b1, 8'h00, rd, oe);
      check("read wiper1", rd, 8'h15);
      check("so_oe_n deselected", so_oe_n, 1'b1);
      id_adr = ~STRAPS;
      cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h2C, rd, oe);
      check("tap_sel1 wrong address", tap1, 64'h1 << 6'h15);
      id_adr = STRAPS;
      $display("Test wiper access done");

      cmd(OP_WR_SETTING, 2'h2, 1'b0, 8'h2A, rd, oe);
      check("pending", pending, 1'b1);
      check("standby busy", standby, 1'b0);
      cmd(OP_RD_STATUS, 2'h0, 1'b1, 8'h00, rd, oe);
      check("status busy", rd, 8'h01);
      nv_wait();
      cmd(OP_RD_STATUS, 2'h0, 1'b1, 8'h00, rd, oe);
      check("status idle", rd, 8'h00);
      cmd(OP_RD_SETTING, 2'h2, 1'b0, 8'h00, rd, oe);
      check("setting0 2", rd, 8'h2A);
      $display("Test setting write done");

      cmd(OP_TO_WIPER, 2'h2, 1'b0, 8'h00, rd, oe);
      check("tap_sel0 transfer", tap0, 64'h1 << 6'h2A);
      cmd(OP_GLB_TO_WIP, 2'h2, 1'b0, 8'h00, rd, oe);
      check("tap_sel1 global", tap1, 64'h1);
      check("tap_sel0 global", tap0, 64'h1 << 6'h2A);
      @(posedge sys_clk);
      #1 wp_n = 1'b0;
      cmd(OP_WR_SETTING, 2'h2, 1'b0, 8'h11, rd, oe);
      check("pending protected", pending, 1'b0);
      @(posedge sys_clk);
      #1 wp_n = 1'b1;
      cmd(OP_RD_SETTING, 2'h2, 1'b0, 8'h00, rd, oe);
      check("setting0 2 protected", rd, 8'h2A);
      $display("Test transfers and protect done");

      cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h33, rd, oe);
      cmd(OP_TO_SETTING, 2'h3, 1'b1, 8'h00, rd, oe);
      nv_wait();
      cmd(OP_GLB_TO_SET, 2'h1, 1'b0, 8'h00, rd, oe);
      nv_wait();
      cmd(OP_RD_SETTING, 2'h3, 1'b1, 8'h00, rd, oe);
      check("setting1 3", rd, 8'h33);
      cmd(OP_RD_SETTING, 2'h1, 1'b0, 8'h00, rd, oe);
      check("setting0 1", rd, 8'h2A);
      cmd(OP_RD_SETTING, 2'h1, 1'b1, 8'h00, rd, oe);
      check("setting1 1", rd, 8'h33);
      $display("Test store transfers done");

      cmd(OP_WR_WIPER, 2'h0, 1'b0, 8'h3E, rd, oe);
      incdec(1'b0, 3, 1'b1);
      check("tap_sel0 top", tap0, 64'h1 << 6'h3F);
      incdec(1'b0, 2, 1'b0);
      check("tap_sel0 down", tap0, 64'h1 << 6'h3D);
      cmd(OP_WR_WIPER, 2'h0, 1'b0, 8'h01, rd, oe);
      incdec(1'b0, 3, 1'b0);
      check("tap_sel0 bottom", tap0, 64'h1);
      $display("Test step done");

      head(OP_WR_WIPER, 2'h0, 1'b1, oe);
      pot_host_i.pause(3);
      pot_host_i.shift(8'h0B, rd, oe);
      pot_host_i.deselect();
      check("tap_sel1 paused", tap1, 64'h1 << 6'h0B);
      head(OP_WR_WIPER, 2'h0, 1'b1, oe);
      pot_host_i.pulses(4, 1'b1);
      pot_host_i.deselect();
      check("tap_sel1 aborted", tap1, 64'h1 << 6'h0B);
      cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h05, rd, oe);
      check("tap_sel1 after abort", tap1, 64'h1 << 6'h05);
      $display("Test pause and abort done");
      complete_run();
   end
endmodule // tb
